// file: hdl/lldma_channel.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// - Destination pointer advances after each write when destination increment is set.
// - Destination writes go to master 0 or master 1 by port select.
// - Destination width field picks byte, halfword or word; resets to word.
// - Source pointer advances after each write when source increment is set.
// - Source reads go to master 0 or master 1 by port select.
// - Source width field picks byte, halfword or word like destination.
// - Each block holds two to the burst exponent accesses.
// - Bytes moved equal length field plus one, rounded up to whole source accesses; codes zero to six unsupported.
// - Next channel field names follow-on channel one to four; zero or five to seven means none.
// - Interrupt enable gates the channel's completion request.
// - Idle gap code n inserts two to the n minus one cycles.
// - Sixteen-bit callback index is readable and writable.
// - Source and destination start addresses come from two registers.
// - List base pointer stores upper thirty bits; low two read zero.
// - Task counts register holds run count and total count halves.
// - List processing starts at the start index field.
// - Read-only list status shows source kind and task state.
// - Read-only current task index reads zero after reset.
// - Next-list enable is stored only, with no effect.
// - Bus protection is stored only, not driven on the bus.
module lldma_channel (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AXI4-Lite register slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // AHB master port 0
  output lldma_pkg::lldma_ahb_req_t m0_req,
  input wire logic [31:0] m0_hrdata,
  input wire logic m0_hready,
  // AHB master port 1
  output lldma_pkg::lldma_ahb_req_t m1_req,
  input wire logic [31:0] m1_hrdata,
  input wire logic m1_hready,
  // Completion and chaining
  output logic irq_request,
  output logic chain_start,
  output logic [2:0] chain_channel
);
  import lldma_pkg::*;

  typedef struct packed {
    lldma_ctrl_t ctrl;
    lldma_ctrl2_t ctrl2;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] lbase;
    logic [31:0] tcount;
    logic [31:0] sidx;
    lldma_eng_t st;
    logic [2:0] lst_state;
    logic [15:0] cur_task;
    logic [31:0] src_ptr;
    logic [31:0] dst_ptr;
    logic [20:0] remaining;
    logic [15:0] beat_cnt;
    logic [14:0] idle_cnt;
    logic [31:0] data;
    lldma_ahb_req_t m0;
    lldma_ahb_req_t m1;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic irq;
    logic chain_go;
    logic [2:0] chain_ch;
  } lldma_state_t;

  lldma_state_t s_r;
  lldma_state_t s_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  function automatic logic [2:0] width_bytes(input logic [1:0] w);
    if (w == WIDTH_BYTE) begin
      return 3'h1;
    end else if (w == WIDTH_HALF) begin
      return 3'h2;
    end
    return 3'h4;
  endfunction

  function automatic logic [2:0] ahb_size(input logic [1:0] w);
    return (w == WIDTH_BYTE || w == WIDTH_HALF) ? {1'b0, w} : {1'b0, WIDTH_WORD};
  endfunction

  function automatic logic [31:0] extract(input logic [31:0] rd, input logic [1:0] lane,
                                          input logic [1:0] w);
    logic [31:0] sh;
    sh = rd >> {lane, 3'b000};
    if (w == WIDTH_BYTE) begin
      return {24'h00_0000, sh[7:0]};
    end else if (w == WIDTH_HALF) begin
      return {16'h0000, sh[15:0]};
    end
    return rd;
  endfunction

  function automatic logic [31:0] place(input logic [31:0] d, input logic [1:0] w);
    if (w == WIDTH_BYTE) begin
      return {4{d[7:0]}};
    end else if (w == WIDTH_HALF) begin
      return {2{d[15:0]}};
    end
    return d;
  endfunction

  function automatic lldma_ahb_req_t make_req(input logic [31:0] addr, input logic wr,
                                              input logic [1:0] w, input logic [31:0] wd);
    lldma_ahb_req_t q;
    q.htrans = HTRANS_NONSEQ;
    q.haddr = addr;
    q.hwrite = wr;
    q.hsize = ahb_size(w);
    q.hwdata = wd;
    return q;
  endfunction

  logic wr_fire;
  logic rd_fire;
  logic src_ready;
  logic dst_ready;
  logic [31:0] src_rdata;

  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_r.bvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !s_r.rvalid;
  assign wr_fire = s_axi_awready;
  assign rd_fire = s_axi_arvalid && !s_r.rvalid;
  assign src_ready = s_r.ctrl.src_port_select ? m1_hready : m0_hready;
  assign dst_ready = s_r.ctrl.dst_port_select ? m1_hready : m0_hready;
  assign src_rdata = s_r.ctrl.src_port_select ? m1_hrdata : m0_hrdata;

  always_comb begin
    logic start_req;
    logic [2:0] step;
    lldma_ahb_req_t rreq;
    lldma_ahb_req_t wreq;
    start_req = 1'b0;
    step = width_bytes(s_r.ctrl.src_access_width);
    rreq = make_req(s_r.src_ptr, 1'b0, s_r.ctrl.src_access_width, 32'h0000_0000);
    wreq = make_req(s_r.dst_ptr, 1'b1, s_r.ctrl.dst_access_width, 32'h0000_0000);
    s_nxt = s_r;
    s_nxt.irq = 1'b0;
    s_nxt.chain_go = 1'b0;

    // Register writes
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      if (s_axi_awaddr == CTRL_ADDR) begin
        s_nxt.ctrl = merge(s_r.ctrl, s_axi_wdata, s_axi_wstrb, 32'hffff_ffff);
      end else if (s_axi_awaddr == CTRL2_ADDR) begin
        s_nxt.ctrl2 = merge(s_r.ctrl2, s_axi_wdata, s_axi_wstrb, CTRL2_MASK);
      end else if (s_axi_awaddr == SRC_ADDR) begin
        s_nxt.src = merge(s_r.src, s_axi_wdata, s_axi_wstrb, 32'hffff_ffff);
      end else if (s_axi_awaddr == DST_ADDR) begin
        s_nxt.dst = merge(s_r.dst, s_axi_wdata, s_axi_wstrb, 32'hffff_ffff);
      end else if (s_axi_awaddr == LBASE_ADDR) begin
        s_nxt.lbase = merge(s_r.lbase, s_axi_wdata, s_axi_wstrb, LBASE_MASK);
      end else if (s_axi_awaddr == TCOUNT_ADDR) begin
        s_nxt.tcount = merge(s_r.tcount, s_axi_wdata, s_axi_wstrb, 32'hffff_ffff);
      end else if (s_axi_awaddr == SIDX_ADDR) begin
        s_nxt.sidx = merge(s_r.sidx, s_axi_wdata, s_axi_wstrb, SIDX_MASK);
      end else if (s_axi_awaddr == CMD_ADDR) begin
        start_req = s_axi_wstrb[0] && s_axi_wdata[CMD_START_BIT];
      end else if (s_axi_awaddr != LSTS_ADDR) begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end

    // Register reads
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      if (s_axi_araddr == CTRL_ADDR) begin
        s_nxt.rdata = s_r.ctrl;
      end else if (s_axi_araddr == CTRL2_ADDR) begin
        s_nxt.rdata = s_r.ctrl2;
      end else if (s_axi_araddr == SRC_ADDR) begin
        s_nxt.rdata = s_r.src;
      end else if (s_axi_araddr == DST_ADDR) begin
        s_nxt.rdata = s_r.dst;
      end else if (s_axi_araddr == LBASE_ADDR) begin
        s_nxt.rdata = s_r.lbase;
      end else if (s_axi_araddr == TCOUNT_ADDR) begin
        s_nxt.rdata = s_r.tcount;
      end else if (s_axi_araddr == SIDX_ADDR) begin
        s_nxt.rdata = s_r.sidx;
      end else if (s_axi_araddr == LSTS_ADDR) begin
        s_nxt.rdata = {12'h000, LST_FROM_REG, s_r.lst_state, s_r.cur_task};
      end else if (s_axi_araddr == CMD_ADDR) begin
        s_nxt.rdata[CMD_BUSY_BIT] = (s_r.st != ENG_IDLE);
      end else begin
        s_nxt.rresp = RESP_SLVERR;
      end
    end

    // Transfer engine
    case (s_r.st)
      ENG_IDLE: begin
        if (start_req) begin
          s_nxt.src_ptr = s_r.src;
          s_nxt.dst_ptr = s_r.dst;
          s_nxt.remaining = {1'b0, s_r.ctrl.total_length} + 21'h00_0001;
          s_nxt.beat_cnt = 16'h0000;
          s_nxt.cur_task = s_r.sidx[15:0];
          s_nxt.lst_state = LST_SET;
          s_nxt.st = ENG_SET;
        end
      end
      ENG_SET: begin
        s_nxt.lst_state = LST_RUN;
        s_nxt.st = ENG_RADDR;
        if (s_r.ctrl.src_port_select) begin
          s_nxt.m1 = rreq;
        end else begin
          s_nxt.m0 = rreq;
        end
      end
      ENG_RADDR: begin
        if (src_ready) begin
          s_nxt.m0.htrans = HTRANS_IDLE;
          s_nxt.m1.htrans = HTRANS_IDLE;
          s_nxt.st = ENG_RDATA;
        end
      end
      ENG_RDATA: begin
        if (src_ready) begin
          s_nxt.data = extract(src_rdata, s_r.src_ptr[1:0], s_r.ctrl.src_access_width);
          s_nxt.st = ENG_WADDR;
          if (s_r.ctrl.dst_port_select) begin
            s_nxt.m1 = wreq;
          end else begin
            s_nxt.m0 = wreq;
          end
        end
      end
      ENG_WADDR: begin
        if (dst_ready) begin
          s_nxt.m0.htrans = HTRANS_IDLE;
          s_nxt.m1.htrans = HTRANS_IDLE;
          // Write data is due in the data phase that starts here
          if (s_r.ctrl.dst_port_select) begin
            s_nxt.m1.hwdata = place(s_r.data, s_r.ctrl.dst_access_width);
          end else begin
            s_nxt.m0.hwdata = place(s_r.data, s_r.ctrl.dst_access_width);
          end
          s_nxt.st = ENG_WDATA;
        end
      end
      ENG_WDATA: begin
        if (dst_ready) begin
          if (s_r.ctrl.src_increment_enable) begin
            s_nxt.src_ptr = s_r.src_ptr + {29'h0, step};
          end
          if (s_r.ctrl.dst_increment_enable) begin
            s_nxt.dst_ptr = s_r.dst_ptr + {29'h0, width_bytes(s_r.ctrl.dst_access_width)};
          end
          rreq.haddr = s_r.ctrl.src_increment_enable ? s_r.src_ptr + {29'h0, step} : s_r.src_ptr;
          if (s_r.remaining <= {18'h0_0000, step}) begin
            s_nxt.remaining = 21'h00_0000;
            s_nxt.lst_state = LST_DONE;
            s_nxt.irq = s_r.ctrl2.irq_enable;
            s_nxt.chain_go = (s_r.ctrl2.next_channel != 3'h0) &&
                             (s_r.ctrl2.next_channel <= 3'h4);
            s_nxt.chain_ch = s_r.ctrl2.next_channel;
            s_nxt.st = ENG_IDLE;
          end else begin
            s_nxt.remaining = s_r.remaining - {18'h0_0000, step};
            if (s_r.beat_cnt == 16'((17'h1 << s_r.ctrl.burst_exponent) - 17'h1)) begin
              s_nxt.beat_cnt = 16'h0000;
            end else begin
              s_nxt.beat_cnt = s_r.beat_cnt + 16'h0001;
            end
            if (s_nxt.beat_cnt == 16'h0000 && s_r.ctrl2.idle_gap_code != 4'h0) begin
              s_nxt.idle_cnt = 15'h0001 << (s_r.ctrl2.idle_gap_code - 4'h1);
              s_nxt.lst_state = LST_WAIT;
              s_nxt.st = ENG_WAIT;
            end else begin
              s_nxt.st = ENG_RADDR;
              if (s_r.ctrl.src_port_select) begin
                s_nxt.m1 = rreq;
              end else begin
                s_nxt.m0 = rreq;
              end
            end
          end
        end
      end
      ENG_WAIT: begin
        if (s_r.idle_cnt == 15'h0001) begin
          s_nxt.lst_state = LST_RUN;
          s_nxt.st = ENG_RADDR;
          if (s_r.ctrl.src_port_select) begin
            s_nxt.m1 = rreq;
          end else begin
            s_nxt.m0 = rreq;
          end
        end else begin
          s_nxt.idle_cnt = s_r.idle_cnt - 15'h0001;
        end
      end
      default: begin
        s_nxt.st = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.ctrl2 <= CTRL2_RST;
      s_r.st <= ENG_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;
  assign m0_req = s_r.m0;
  assign m1_req = s_r.m1;
  assign irq_request = s_r.irq;
  assign chain_start = s_r.chain_go;
  assign chain_channel = s_r.chain_ch;

endmodule // lldma_channel

// file: hdl/lldma_pkg.sv
package lldma_pkg;

  // Register byte addresses
  localparam logic [31:0] CTRL_ADDR = 32'h5006_0400;
  localparam logic [31:0] CTRL2_ADDR = 32'h5006_0404;
  localparam logic [31:0] SRC_ADDR = 32'h5006_0408;
  localparam logic [31:0] DST_ADDR = 32'h5006_040c;
  localparam logic [31:0] LBASE_ADDR = 32'h5006_0410;
  localparam logic [31:0] TCOUNT_ADDR = 32'h5006_0414;
  localparam logic [31:0] SIDX_ADDR = 32'h5006_0418;
  localparam logic [31:0] LSTS_ADDR = 32'h5006_0420;
  localparam logic [31:0] CMD_ADDR = 32'h5006_0424;

  // Reset values and writable masks
  localparam logic [31:0] CTRL_RST = 32'hea00_0000;
  localparam logic [31:0] CTRL2_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL2_MASK = 32'h0fff_ffff;
  localparam logic [31:0] LBASE_MASK = 32'hffff_fffc;
  localparam logic [31:0] SIDX_MASK = 32'h0000_ffff;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_BUSY_BIT = 0;

  // Access width codes
  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;

  // List status codes
  localparam logic [2:0] LST_IDLE = 3'h0;
  localparam logic [2:0] LST_SET = 3'h1;
  localparam logic [2:0] LST_RUN = 3'h2;
  localparam logic [2:0] LST_DONE = 3'h3;
  localparam logic [2:0] LST_WAIT = 3'h4;
  localparam logic LST_FROM_REG = 1'b0;

  // Bus codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic dst_increment_enable;
    logic dst_port_select;
    logic [1:0] dst_access_width;
    logic src_increment_enable;
    logic src_port_select;
    logic [1:0] src_access_width;
    logic [3:0] burst_exponent;
    logic [19:0] total_length;
  } lldma_ctrl_t;

  typedef struct packed {
    logic [3:0] reserved;
    logic next_list_enable;
    logic [2:0] next_channel;
    logic [2:0] bus_protection;
    logic irq_enable;
    logic [3:0] idle_gap_code;
    logic [15:0] callback_index;
  } lldma_ctrl2_t;

  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } lldma_ahb_req_t;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000,
    ENG_SET = 3'b001,
    ENG_RADDR = 3'b010,
    ENG_RDATA = 3'b011,
    ENG_WADDR = 3'b100,
    ENG_WDATA = 3'b101,
    ENG_WAIT = 3'b110
  } lldma_eng_t;

endpackage

// file: tb/lldma_ahb_mem.sv
`timescale 1ns/1ps
module lldma_ahb_mem (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bus from the channel
  input wire lldma_pkg::lldma_ahb_req_t req,
  output logic [31:0] hrdata,
  output logic hready,
  // Stall every other cycle
  input wire logic slow
);
  import lldma_pkg::*;
  logic [31:0] mem [0:63];
  logic [31:0] junk_r;
  logic stall_r, dph_r, dwr_r;
  logic [7:0] dadr_r;
  logic [2:0] dsz_r;
  logic [3:0] lanes;
  assign hready = !(slow && stall_r);
  // Outside a read data phase the data lines carry a changing pattern
  assign hrdata = (dph_r && !dwr_r) ? mem[dadr_r[7:2]] : junk_r;
  always_comb begin
    case (dsz_r)
      3'h0: lanes = 4'h1 << dadr_r[1:0];
      3'h1: lanes = dadr_r[1] ? 4'hc : 4'h3;
      default: lanes = 4'hf;
    endcase
  end
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      junk_r <= 32'h5a5a_a5a5;
      stall_r <= 1'b0;
      dph_r <= 1'b0;
    end else begin
      junk_r <= ~junk_r;
      stall_r <= !stall_r;
      if (hready) begin
        for (int i = 0; i < 4; i++)
          if (dph_r && dwr_r && lanes[i]) mem[dadr_r[7:2]][8*i +: 8] <= req.hwdata[8*i +: 8];
        dph_r <= req.htrans == HTRANS_NONSEQ;
        dwr_r <= req.hwrite;
        dadr_r <= req.haddr[7:0];
        dsz_r <= req.hsize;
      end
    end
  end
endmodule // lldma_ahb_mem

// file: tb/lldma_channel_properties.sv
`timescale 1ns/1ps
module lldma_channel_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Bus masters
  input wire lldma_pkg::lldma_ahb_req_t m0_req,
  input wire logic m0_hready,
  input wire lldma_pkg::lldma_ahb_req_t m1_req,
  input wire logic m1_hready,
  // Completion
  input wire logic irq_request,
  input wire logic chain_start,
  input wire logic [2:0] chain_channel
);
  import lldma_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_m1_stall;
    m1_req.htrans == HTRANS_NONSEQ && !m1_hready;
  endsequence
  chk_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write not answered");
  chk_write_order: assert property (s_axi_awready |-> !s_axi_bvalid)
    else $error("write taken while response pending");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_irq_pulse: assert property (irq_request |=> !irq_request)
    else $error("interrupt request too long");
  chk_chain_target: assert property (chain_start |-> chain_channel inside {[3'h1:3'h4]})
    else $error("chain to invalid channel");
  chk_one_port: assert property (!(m0_req.htrans == HTRANS_NONSEQ && m1_req.htrans == HTRANS_NONSEQ))
    else $error("both ports active");
  chk_addr_hold: assert property (s_m1_stall |=> m1_req.htrans == HTRANS_NONSEQ && $stable(m1_req.haddr))
    else $error("address phase not held");
  chk_single_beat: assert property (m0_req.htrans == HTRANS_NONSEQ && m0_hready |=> m0_req.htrans == HTRANS_IDLE)
    else $error("pipelined transfer");
  chk_width_legal: assert property (m0_req.htrans == HTRANS_NONSEQ |-> m0_req.hsize <= 3'h2)
    else $error("illegal transfer size");
endmodule // lldma_channel_properties

bind lldma_channel lldma_channel_properties chk_inst (.ref_clk(ref_clk), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .m0_req(m0_req), .m0_hready(m0_hready), .m1_req(m1_req),
  .m1_hready(m1_hready), .irq_request(irq_request), .chain_start(chain_start),
  .chain_channel(chain_channel));

// file: tb/lldma_channel_tb_top.sv
`timescale 1ns/1ps
module lldma_channel_tb_top;
  import lldma_pkg::*;
  logic ref_clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, m0_hready, m1_hready, slow1;
  logic irq_request, chain_start, wait_seen;
  logic [31:0] awaddr, wdata, araddr, rdata, m0_hrdata, m1_hrdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] chain_channel;
  lldma_ahb_req_t m0_req, m1_req;
  int errors, tests_run, irq_cnt, chain_cnt, ready_lag;

  lldma_channel lldma_channel_inst (.ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .m0_req(m0_req), .m0_hrdata(m0_hrdata), .m0_hready(m0_hready),
    .m1_req(m1_req), .m1_hrdata(m1_hrdata), .m1_hready(m1_hready),
    .irq_request(irq_request), .chain_start(chain_start), .chain_channel(chain_channel));
  lldma_ahb_mem lldma_ahb_mem_inst0 (.ref_clk(ref_clk), .reset(reset), .req(m0_req),
    .hrdata(m0_hrdata), .hready(m0_hready), .slow(1'b0));
  lldma_ahb_mem lldma_ahb_mem_inst1 (.ref_clk(ref_clk), .reset(reset), .req(m1_req),
    .hrdata(m1_hrdata), .hready(m1_hready), .slow(slow1));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (irq_request === 1'b1) irq_cnt++;
    if (chain_start === 1'b1) chain_cnt++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (ready_lag == 0);
    do @(posedge ref_clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    repeat (ready_lag) @(posedge ref_clk);
    bready <= 1'b1;
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    chk(bresp, e);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, input logic [1:0] e);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (ready_lag == 0);
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat (ready_lag) @(posedge ref_clk);
    rready <= 1'b1;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    chk(rresp, e);
    rready <= 1'b0;
  endtask
  // Start the channel and poll busy, noting any idle gap seen in status
  task automatic run_wait();
    logic [31:0] v;
    wait_seen = 1'b0;
    irq_cnt = 0;
    chain_cnt = 0;
    wr(CMD_ADDR, 32'h1, RESP_OKAY);
    for (int n = 0; n < 200; n++) begin
      rd(LSTS_ADDR, v, RESP_OKAY);
      if (v[18:16] === 3'h4) wait_seen = 1'b1;
      rd(CMD_ADDR, v, RESP_OKAY);
      if (v[0] === 1'b0) break;
    end
    chk(v[0], 1'b0);
  endtask

  task automatic t_reset_vals();
    logic [31:0] v;
    logic [31:0] a [8] = '{CTRL_ADDR, CTRL2_ADDR, SRC_ADDR, DST_ADDR, LBASE_ADDR,
      TCOUNT_ADDR, SIDX_ADDR, LSTS_ADDR};
    for (int i = 0; i < 8; i++) begin
      rd(a[i], v, RESP_OKAY);
      chk(v, (i == 0) ? 32'hea00_0000 : 32'h0);
    end
  endtask
  task automatic t_reg_access();
    logic [31:0] v;
    logic [31:0] a [7] = '{CTRL_ADDR, CTRL2_ADDR, SRC_ADDR, DST_ADDR, LBASE_ADDR, TCOUNT_ADDR,
      SIDX_ADDR};
    logic [31:0] e [7] = '{32'hfda5_c3c6, 32'h0da5_c3c6, 32'hfda5_c3c6, 32'hfda5_c3c6,
      32'hfda5_c3c4, 32'hfda5_c3c6, 32'h0000_c3c6};
    // Late ready makes the slave hold its answers
    ready_lag = 2;
    for (int i = 0; i < 7; i++) begin
      wr(a[i], 32'hfda5_c3c6, RESP_OKAY);
      rd(a[i], v, RESP_OKAY);
      chk(v, e[i]);
    end
    ready_lag = 0;
    wr(LSTS_ADDR, 32'hffff_ffff, RESP_OKAY);
    rd(LSTS_ADDR, v, RESP_OKAY);
    chk(v, 32'h0);
    wr(32'h5006_041c, 32'hffff_ffff, RESP_SLVERR);
    rd(32'h5006_041c, v, RESP_SLVERR);
    chk(v, 32'h0);
  endtask
  task automatic t_xfer_word();
    logic [31:0] v;
    lldma_ahb_mem_inst0.mem[4] = 32'h1122_3344;
    lldma_ahb_mem_inst0.mem[5] = 32'h5566_7788;
    wr(SRC_ADDR, 32'h10, RESP_OKAY);
    wr(DST_ADDR, 32'h40, RESP_OKAY);
    wr(SIDX_ADDR, 32'h5, RESP_OKAY);
    wr(CTRL_ADDR, 32'hea00_0007, RESP_OKAY);
    wr(CTRL2_ADDR, 32'h0310_0000, RESP_OKAY);
    run_wait();
    rd(LSTS_ADDR, v, RESP_OKAY);
    chk(v, 32'h0003_0005);
    chk(lldma_ahb_mem_inst1.mem[16], 32'h1122_3344);
    chk(lldma_ahb_mem_inst1.mem[17], 32'h5566_7788);
    chk(lldma_ahb_mem_inst1.mem[18], 32'h0);
    chk(irq_cnt, 1);
    chk(chain_cnt, 1);
    chk(chain_channel, 3'h3);
  endtask
  task automatic t_xfer_byte();
    logic [31:0] v;
    lldma_ahb_mem_inst1.mem[8] = 32'h0302_0100;
    lldma_ahb_mem_inst1.mem[9] = 32'h0706_0504;
    slow1 <= 1'b1;
    wr(SRC_ADDR, 32'h20, RESP_OKAY);
    wr(DST_ADDR, 32'h41, RESP_OKAY);
    wr(CTRL_ADDR, 32'h0c10_0007, RESP_OKAY);
    wr(CTRL2_ADDR, 32'h0504_0000, RESP_OKAY);
    run_wait();
    rd(LSTS_ADDR, v, RESP_OKAY);
    chk(v[19:16], 4'h3);
    chk(lldma_ahb_mem_inst0.mem[16], 32'h0000_0700);
    chk(wait_seen, 1'b1);
    chk(irq_cnt, 0);
    chk(chain_cnt, 0);
    slow1 <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready, slow1} = '0;
    wstrb = 4'hf;
    for (int i = 0; i < 64; i++) begin
      lldma_ahb_mem_inst0.mem[i] = 32'h0;
      lldma_ahb_mem_inst1.mem[i] = 32'h0;
    end
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_vals();
    t_reg_access();
    t_xfer_word();
    t_xfer_byte();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end
endmodule // lldma_channel_tb_top
